/* File: hdl/ftlc_pkg.sv */
// package: register map, reset values and encodings for the fan limit block
package ftlc_pkg;
  localparam logic [7:0] ADDR_PWM1_FLOOR = 8'h64;
  localparam logic [7:0] ADDR_PWM2_FLOOR = 8'h65;
  localparam logic [7:0] ADDR_PWM3_FLOOR = 8'h66;
  localparam logic [7:0] ADDR_R1_START = 8'h67;
  localparam logic [7:0] ADDR_LOC_START = 8'h68;
  localparam logic [7:0] ADDR_R2_START = 8'h69;
  localparam logic [7:0] ADDR_R1_CRIT = 8'h6A;
  localparam logic [7:0] ADDR_LOC_CRIT = 8'h6B;
  localparam logic [7:0] ADDR_R2_CRIT = 8'h6C;
  localparam logic [7:0] ADDR_R1_LOC_HYST = 8'h6D;
  localparam logic [7:0] ADDR_R2_HYST = 8'h6E;
  localparam logic [7:0] RST_FLOOR_DUTY = 8'h80;
  localparam logic [7:0] RST_START_TEMP = 8'h5A;
  localparam logic [7:0] RST_CRIT_LIMIT = 8'h64;
  localparam logic [7:0] RST_R1_LOC_HYST = 8'h44;
  localparam logic [7:0] RST_R2_HYST = 8'h40;
  localparam logic [7:0] CRIT_DISABLE_CODE = 8'h80;
  localparam logic [7:0] DUTY_FULL = 8'hFF;
  localparam logic [7:0] DUTY_OFF = 8'h00;
  localparam int LOCAL_HYST_LSB = 0;
  localparam int REMOTE1_HYST_LSB = 4;
  localparam int REMOTE2_HYST_LSB = 4;
  localparam int HYST_W = 4;
  localparam int CH_R1 = 0;
  localparam int CH_LOC = 1;
  localparam int CH_R2 = 2;
  localparam int NUM_CH = 3;
  // one temperature step per degree; quarter-degree bits sit below it
  localparam int FRAC_W = 2;
  localparam logic [9:0] ALARM_MARGIN_Q = 10'h001;
  typedef enum logic [1:0] {CH_IDLE, CH_RUN, CH_HOLD} ftlc_ch_state_t;
endpackage

/* File: hdl/ftlc_regfile.sv */
// register storage for the fan limit block with registered read data
`timescale 1ns/1ps
`default_nettype none
module ftlc_regfile
  import ftlc_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic wr_en,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic config_lock,
  input wire logic auto_mode,
  output logic [7:0] rdata_ff,
  output logic [7:0] floor_duty [NUM_CH],
  output logic [7:0] fan_start_temp [NUM_CH],
  output logic [7:0] crit_limit [NUM_CH],
  output logic [7:0] r1_loc_hyst,
  output logic [7:0] r2_hyst
);
  logic [7:0] floor_ff [NUM_CH];
  logic [7:0] start_ff [NUM_CH];
  logic [7:0] crit_ff [NUM_CH];
  logic [7:0] hyst_a_ff;
  logic [7:0] hyst_b_ff;
  logic wr_floor_ok;
  logic wr_lim_ok;

  // automatic loop owns the floors; lock freezes the limits
  assign wr_floor_ok = wr_en && !auto_mode;
  assign wr_lim_ok = wr_en && !config_lock;

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      for (int i = 0; i < NUM_CH; i++)
      begin
        floor_ff[i] <= RST_FLOOR_DUTY;
        start_ff[i] <= RST_START_TEMP;
        crit_ff[i] <= RST_CRIT_LIMIT;
      end
      hyst_a_ff <= RST_R1_LOC_HYST;
      hyst_b_ff <= RST_R2_HYST;
    end
    else
    begin
      if (wr_floor_ok)
      begin
        case (addr)
          ADDR_PWM1_FLOOR: floor_ff[0] <= wdata;
          ADDR_PWM2_FLOOR: floor_ff[1] <= wdata;
          ADDR_PWM3_FLOOR: floor_ff[2] <= wdata;
          default: ;
        endcase
      end
      if (wr_lim_ok)
      begin
        case (addr)
          ADDR_R1_START: start_ff[CH_R1] <= wdata;
          ADDR_LOC_START: start_ff[CH_LOC] <= wdata;
          ADDR_R2_START: start_ff[CH_R2] <= wdata;
          ADDR_R1_CRIT: crit_ff[CH_R1] <= wdata;
          ADDR_LOC_CRIT: crit_ff[CH_LOC] <= wdata;
          ADDR_R2_CRIT: crit_ff[CH_R2] <= wdata;
          ADDR_R1_LOC_HYST: hyst_a_ff <= wdata;
          ADDR_R2_HYST: hyst_b_ff <= wdata;
          default: ;
        endcase
      end
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      rdata_ff <= 8'h00;
    end
    else
    begin
      case (addr)
        ADDR_PWM1_FLOOR: rdata_ff <= floor_ff[0];
        ADDR_PWM2_FLOOR: rdata_ff <= floor_ff[1];
        ADDR_PWM3_FLOOR: rdata_ff <= floor_ff[2];
        ADDR_R1_START: rdata_ff <= start_ff[CH_R1];
        ADDR_LOC_START: rdata_ff <= start_ff[CH_LOC];
        ADDR_R2_START: rdata_ff <= start_ff[CH_R2];
        ADDR_R1_CRIT: rdata_ff <= crit_ff[CH_R1];
        ADDR_LOC_CRIT: rdata_ff <= crit_ff[CH_LOC];
        ADDR_R2_CRIT: rdata_ff <= crit_ff[CH_R2];
        ADDR_R1_LOC_HYST: rdata_ff <= hyst_a_ff;
        ADDR_R2_HYST: rdata_ff <= hyst_b_ff;
        default: rdata_ff <= 8'h00;
      endcase
    end
  end

  assign floor_duty = floor_ff;
  assign fan_start_temp = start_ff;
  assign crit_limit = crit_ff;
  assign r1_loc_hyst = hyst_a_ff;
  assign r2_hyst = hyst_b_ff;
endmodule
`default_nettype wire

/* File: hdl/ftlc_top.sv */
// fan start, floor duty and critical over-temperature limit logic
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - three floor-duty registers at 0x64..0x66, reset 0x80
// - floor duty is linear: 0x00 off, 0xFF full
// - floor-duty registers ignore writes while automatic mode runs
// - three start temperature registers at 0x67..0x69, reset 0x5A
// - above start temperature, fan runs from floor rising with temperature
// - lock bit makes start, critical and hysteresis registers read-only
// - three critical limit registers at 0x6A..0x6C, reset 0x64
// - any channel over its critical limit forces every output full
// - critical limit value 0x80 disables that channel's fail-safe
// - full duty holds until temperature below limit minus hysteresis
// - alarm pin, when output, pulls low 0.25 degrees above limit
// - 0x6D holds local hysteresis 3:0, remote 1 7:4, reset 0x44
// - 0x6E holds remote 2 hysteresis in 7:4, reset 0x40
// - below start, floor duty holds until start minus hysteresis
// - hysteresis fields are 0..15 degrees per channel
module ftlc_top
  import ftlc_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic reg_wr_en,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata_ff,
  input wire logic config_lock,
  input wire logic auto_mode,
  input wire logic alarm_as_output,
  input wire logic [9:0] temp_r1_q,
  input wire logic [9:0] temp_loc_q,
  input wire logic [9:0] temp_r2_q,
  input wire logic [7:0] span_r1,
  input wire logic [7:0] span_loc,
  input wire logic [7:0] span_r2,
  input wire logic critical_alarm_in,
  output logic critical_alarm_out_ff,
  output logic critical_alarm_oe_ff,
  output logic [7:0] pwm_duty1_ff,
  output logic [7:0] pwm_duty2_ff,
  output logic [7:0] pwm_duty3_ff,
  output logic [2:0] fan_running_ff,
  output logic [2:0] crit_trip_ff
);
  import ftlc_pkg::*;

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  logic [7:0] floor_duty [NUM_CH];
  logic [7:0] fan_start_temp [NUM_CH];
  logic [7:0] crit_limit [NUM_CH];
  logic [7:0] r1_loc_hyst;
  logic [7:0] r2_hyst;
  logic [7:0] rdata;

  ftlc_regfile u_regs (
    .mclk(mclk),
    .rst(rst),
    .wr_en(reg_wr_en),
    .addr(reg_addr),
    .wdata(reg_wdata),
    .config_lock(config_lock),
    .auto_mode(auto_mode),
    .rdata_ff(rdata),
    .floor_duty(floor_duty),
    .fan_start_temp(fan_start_temp),
    .crit_limit(crit_limit),
    .r1_loc_hyst(r1_loc_hyst),
    .r2_hyst(r2_hyst)
  );

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      reg_rdata_ff <= 8'h00;
    end
    else
    begin
      reg_rdata_ff <= rdata;
    end
  end

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  // degrees minus hysteresis, clamped at zero so a low limit never wraps
  function automatic logic [7:0] sub_hyst(input logic [7:0] deg, input logic [3:0] hyst);
    logic [8:0] diff;
    diff = {1'b0, deg} - {5'h00, hyst};
    sub_hyst = diff[8] ? 8'h00 : diff[7:0];
  endfunction

  // floor + (temp - start) * 256 / span, saturating at full
  function automatic logic [7:0] ramp_duty(input logic [7:0] floor, input logic [7:0] excess,
                                           input logic [7:0] span);
    logic [16:0] step;
    logic [16:0] sum;
    step = 17'(({9'h000, excess} << 8) / {9'h000, (span == 8'h00) ? 8'h01 : span});
    sum = step + {9'h000, floor};
    ramp_duty = (sum > 17'h000FF) ? DUTY_FULL : sum[7:0];
  endfunction

  logic [7:0] temp_deg [NUM_CH];
  logic [9:0] temp_q [NUM_CH];
  logic [7:0] span [NUM_CH];
  logic [3:0] hyst [NUM_CH];

  assign temp_q[CH_R1] = temp_r1_q;
  assign temp_q[CH_LOC] = temp_loc_q;
  assign temp_q[CH_R2] = temp_r2_q;
  assign span[CH_R1] = span_r1;
  assign span[CH_LOC] = span_loc;
  assign span[CH_R2] = span_r2;
  assign hyst[CH_LOC] = r1_loc_hyst[LOCAL_HYST_LSB +: HYST_W];
  assign hyst[CH_R1] = r1_loc_hyst[REMOTE1_HYST_LSB +: HYST_W];
  assign hyst[CH_R2] = r2_hyst[REMOTE2_HYST_LSB +: HYST_W];

  // ------------------------------------------------------------
  // per-channel start and critical tracking
  // ------------------------------------------------------------
  ftlc_ch_state_t ch_state_ff [NUM_CH];
  logic [2:0] trip_ff;
  logic [2:0] crit_enabled;
  logic [2:0] alarm_over;
  logic [7:0] ch_duty [NUM_CH];

  always_comb
  begin
    for (int c = 0; c < NUM_CH; c++)
    begin
      temp_deg[c] = temp_q[c][9:FRAC_W];
      crit_enabled[c] = (crit_limit[c] != CRIT_DISABLE_CODE);
      // quarter degree above the limit, in quarter-degree units
      alarm_over[c] = crit_enabled[c] &&
                      (temp_q[c] >= ({crit_limit[c], 2'b00} + ALARM_MARGIN_Q));
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      for (int c = 0; c < NUM_CH; c++)
      begin
        ch_state_ff[c] <= CH_IDLE;
      end
    end
    else
    begin
      for (int c = 0; c < NUM_CH; c++)
      begin
        case (ch_state_ff[c])
          CH_IDLE:
          begin
            if (temp_deg[c] > fan_start_temp[c])
            begin
              ch_state_ff[c] <= CH_RUN;
            end
          end
          CH_RUN:
          begin
            if (temp_deg[c] < fan_start_temp[c])
            begin
              ch_state_ff[c] <= CH_HOLD;
            end
          end
          CH_HOLD:
          begin
            if (temp_deg[c] > fan_start_temp[c])
            begin
              ch_state_ff[c] <= CH_RUN;
            end
            else if (temp_deg[c] <= sub_hyst(fan_start_temp[c], hyst[c]))
            begin
              ch_state_ff[c] <= CH_IDLE;
            end
          end
          default: ch_state_ff[c] <= CH_IDLE;
        endcase
      end
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      trip_ff <= 3'h0;
    end
    else
    begin
      for (int c = 0; c < NUM_CH; c++)
      begin
        if (!crit_enabled[c])
        begin
          trip_ff[c] <= 1'b0;
        end
        else if (temp_deg[c] > crit_limit[c])
        begin
          trip_ff[c] <= 1'b1;
        end
        else if (temp_deg[c] < sub_hyst(crit_limit[c], hyst[c]))
        begin
          trip_ff[c] <= 1'b0;
        end
      end
    end
  end

  // ------------------------------------------------------------
  // duty selection
  // ------------------------------------------------------------
  // each output follows the channel with the same index; a limitation,
  // since a fuller part routes channels to outputs through config bits
  always_comb
  begin
    for (int c = 0; c < NUM_CH; c++)
    begin
      case (ch_state_ff[c])
        CH_RUN:
        begin
          ch_duty[c] = (temp_deg[c] > fan_start_temp[c]) ?
                       ramp_duty(floor_duty[c], temp_deg[c] - fan_start_temp[c], span[c]) :
                       floor_duty[c];
        end
        CH_HOLD: ch_duty[c] = floor_duty[c];
        default: ch_duty[c] = DUTY_OFF;
      endcase
    end
  end

  // manual drive: hold the programmed floor (fan off at 0x00)
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      pwm_duty1_ff <= DUTY_OFF;
    end
    else if (|trip_ff)
    begin
      pwm_duty1_ff <= DUTY_FULL;
    end
    else if (auto_mode)
    begin
      pwm_duty1_ff <= ch_duty[0];
    end
    else
    begin
      pwm_duty1_ff <= floor_duty[0];
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      pwm_duty2_ff <= DUTY_OFF;
    end
    else if (|trip_ff)
    begin
      pwm_duty2_ff <= DUTY_FULL;
    end
    else if (auto_mode)
    begin
      pwm_duty2_ff <= ch_duty[1];
    end
    else
    begin
      pwm_duty2_ff <= floor_duty[1];
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      pwm_duty3_ff <= DUTY_OFF;
    end
    else if (|trip_ff)
    begin
      pwm_duty3_ff <= DUTY_FULL;
    end
    else if (auto_mode)
    begin
      pwm_duty3_ff <= ch_duty[2];
    end
    else
    begin
      pwm_duty3_ff <= floor_duty[2];
    end
  end

  // ------------------------------------------------------------
  // status and alarm pin
  // ------------------------------------------------------------
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      fan_running_ff <= 3'h0;
    end
    else
    begin
      for (int c = 0; c < NUM_CH; c++)
      begin
        fan_running_ff[c] <= (ch_state_ff[c] != CH_IDLE);
      end
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      crit_trip_ff <= 3'h0;
    end
    else
    begin
      crit_trip_ff <= trip_ff;
    end
  end

  // open drain: output level always low, only the enable moves
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      critical_alarm_out_ff <= 1'b0;
      critical_alarm_oe_ff <= 1'b0;
    end
    else
    begin
      critical_alarm_out_ff <= 1'b0;
      critical_alarm_oe_ff <= alarm_as_output && (|alarm_over);
    end
  end

  // input side of the pin is owned by the monitoring logic elsewhere
  logic unused_alarm_in;
  assign unused_alarm_in = critical_alarm_in;
endmodule
`default_nettype wire

/* File: test/ftlc_fan_model.sv */
// fan and alarm-line model standing on the pwm and alarm pins
`timescale 1ns/1ps
`default_nettype none
module ftlc_fan_model
(
  input wire logic [7:0] duty1,
  input wire logic [7:0] duty2,
  input wire logic [7:0] duty3,
  input wire logic alarm_oe,
  input wire logic alarm_out,
  output logic alarm_pin,
  output logic [2:0] spinning
);
  import ftlc_pkg::*;
  // ----------------------------
  // pins
  // ----------------------------
  // pulled up off chip, so a released line reads high
  assign alarm_pin = alarm_oe ? alarm_out : 1'b1;
  // a zero duty stops the fan outright
  assign spinning = {duty3 != DUTY_OFF, duty2 != DUTY_OFF, duty1 != DUTY_OFF};
endmodule
`default_nettype wire

/* File: test/ftlc_checker.sv */
// checker: concurrent properties on the fan limit block ports
`timescale 1ns/1ps
`default_nettype none
module ftlc_checker
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic reg_wr_en,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata_ff,
  input wire logic config_lock,
  input wire logic alarm_as_output,
  input wire logic [9:0] temp_loc_q,
  input wire logic critical_alarm_out_ff,
  input wire logic critical_alarm_oe_ff,
  input wire logic [7:0] pwm_duty1_ff,
  input wire logic [7:0] pwm_duty2_ff,
  input wire logic [7:0] pwm_duty3_ff,
  input wire logic [2:0] crit_trip_ff
);
  import ftlc_pkg::*;
  // ----------------------------
  // local channel shadow
  // ----------------------------
  // only local is mirrored, to keep the helper small
  logic [7:0] lim_ff;
  logic [3:0] hyst_ff;
  logic [7:0] deg;
  assign deg = temp_loc_q[9:2];
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      lim_ff <= RST_CRIT_LIMIT;
      hyst_ff <= RST_R1_LOC_HYST[3:0];
    end
    else if (reg_wr_en && !config_lock)
    begin
      if (reg_addr == ADDR_LOC_CRIT)
        lim_ff <= reg_wdata;
      if (reg_addr == ADDR_R1_LOC_HYST)
        hyst_ff <= reg_wdata[3:0];
    end
  end
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);
  chk_alarm_pin_low:
    assert property (critical_alarm_out_ff == 1'b0) else $error("alarm level not low");
  chk_alarm_drive_on:
    assert property (alarm_as_output && lim_ff != CRIT_DISABLE_CODE
      && temp_loc_q >= {lim_ff, 2'b00} + ALARM_MARGIN_Q |=> critical_alarm_oe_ff)
    else $error("alarm not driven over limit");
  chk_alarm_quiet:
    assert property (!alarm_as_output |=> !critical_alarm_oe_ff) else $error("alarm driven");
  chk_trip_full_duty:
    assert property (|crit_trip_ff |-> (pwm_duty1_ff & pwm_duty2_ff & pwm_duty3_ff) == DUTY_FULL)
    else $error("trip without full duty");
  chk_trip_sets:
    assert property (deg > lim_ff && lim_ff != CRIT_DISABLE_CODE |-> ##2 crit_trip_ff[CH_LOC])
    else $error("local trip missing");
  chk_trip_off_code:
    assert property (lim_ff == CRIT_DISABLE_CODE |-> ##2 !crit_trip_ff[CH_LOC])
    else $error("disabled channel tripped");
  chk_trip_release:
    assert property (({1'b0, deg} + 9'(hyst_ff)) < {1'b0, lim_ff} |-> ##2 !crit_trip_ff[CH_LOC])
    else $error("local trip not released");
  chk_limit_readback:
    assert property ((reg_addr == ADDR_LOC_CRIT && !reg_wr_en)[*3] |-> reg_rdata_ff == lim_ff)
    else $error("limit readback wrong");
  chk_unmapped_read:
    assert property ((reg_addr == 8'h6F)[*3] |-> reg_rdata_ff == 8'h00)
    else $error("unmapped read not zero");
endmodule
bind ftlc_top ftlc_checker u_chk (.mclk, .rst, .reg_wr_en, .reg_addr, .reg_wdata, .reg_rdata_ff,
  .config_lock, .alarm_as_output, .temp_loc_q, .critical_alarm_out_ff, .critical_alarm_oe_ff,
  .pwm_duty1_ff, .pwm_duty2_ff, .pwm_duty3_ff, .crit_trip_ff);
`default_nettype wire

/* File: test/ftlc_top_tb.sv */
// testbench: register, start-temperature and critical-limit scenarios
`timescale 1ns/1ps
`default_nettype none
module ftlc_top_tb;
  import ftlc_pkg::*;
  logic mclk, rst = 1'b1, reg_wr_en = 1'b0, config_lock = 1'b0, auto_mode = 1'b0;
  logic alarm_as_output = 1'b0, alarm_pin, critical_alarm_out_ff, critical_alarm_oe_ff;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata_ff;
  logic [7:0] pwm_duty1_ff, pwm_duty2_ff, pwm_duty3_ff;
  logic [7:0] span_r1 = 8'h10, span_loc = 8'h10, span_r2 = 8'h10;
  logic [9:0] temp_r1_q = 10'h064, temp_loc_q = 10'h064, temp_r2_q = 10'h064;
  logic [2:0] fan_running_ff, crit_trip_ff, spin;
  int failures = 0, cmp_count = 0;
  ftlc_top u_dut (.mclk, .rst, .reg_wr_en, .reg_addr, .reg_wdata, .reg_rdata_ff, .config_lock,
    .auto_mode, .alarm_as_output, .temp_r1_q, .temp_loc_q, .temp_r2_q, .span_r1, .span_loc,
    .span_r2, .critical_alarm_in(alarm_pin), .critical_alarm_out_ff, .critical_alarm_oe_ff,
    .pwm_duty1_ff, .pwm_duty2_ff, .pwm_duty3_ff, .fan_running_ff, .crit_trip_ff);
  ftlc_fan_model u_fan (.duty1(pwm_duty1_ff), .duty2(pwm_duty2_ff), .duty3(pwm_duty3_ff),
    .alarm_oe(critical_alarm_oe_ff), .alarm_out(critical_alarm_out_ff), .alarm_pin,
    .spinning(spin));
  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // ----------------------------
  // shared tasks
  // ----------------------------
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic check(input logic [23:0] got, input logic [23:0] e);
    cmp_count++;
    if (got !== e)
    begin
      failures++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, e);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr_en <= 1'b1;
    @(posedge mclk);
    reg_wr_en <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge mclk);
    reg_addr <= a;
    tick(3);
    #1;
    check(24'(reg_rdata_ff), 24'(e));
  endtask
  task automatic temps(input logic [7:0] a, input logic [7:0] b, input logic [7:0] c);
    @(posedge mclk);
    temp_r1_q <= {a, 2'b00};
    temp_loc_q <= {b, 2'b00};
    temp_r2_q <= {c, 2'b00};
  endtask
  // waits for duties and status to match together, then judges duties and status in separate checks
  task automatic expect_out(input logic [23:0] e, input logic [5:0] s);
    int i;
    for (i = 0; i < 8; i++)
    begin
      @(posedge mclk);
      #1;
      if ({pwm_duty1_ff, pwm_duty2_ff, pwm_duty3_ff, fan_running_ff, crit_trip_ff} === {e, s})
        break;
    end
    check({pwm_duty1_ff, pwm_duty2_ff, pwm_duty3_ff}, e);
    check(24'({fan_running_ff, crit_trip_ff}), 24'(s));
    if (i == 8)
      end_of_test();
  endtask
  // ----------------------------
  // scenarios
  // ----------------------------
  task automatic t_reset();
    logic [7:0] e;
    for (int a = 'h64; a <= 'h6E; a++)
    begin
      e = a < 'h67 ? RST_FLOOR_DUTY : a < 'h6A ? RST_START_TEMP : RST_CRIT_LIMIT;
      e = a == 'h6D ? RST_R1_LOC_HYST : a == 'h6E ? RST_R2_HYST : e;
      rd(8'(a), e);
    end
    rd(8'h6F, 8'h00);
    $display("done: reset values");
  endtask
  task automatic t_regs();
    @(posedge mclk);
    config_lock <= 1'b1;
    wr(ADDR_R1_START, 8'h30);
    wr(ADDR_LOC_CRIT, 8'h30);
    wr(ADDR_R1_LOC_HYST, 8'h55);
    wr(ADDR_PWM1_FLOOR, 8'h40);
    rd(ADDR_R1_START, RST_START_TEMP);
    rd(ADDR_LOC_CRIT, RST_CRIT_LIMIT);
    rd(ADDR_R1_LOC_HYST, RST_R1_LOC_HYST);
    rd(ADDR_PWM1_FLOOR, 8'h40);
    @(posedge mclk);
    config_lock <= 1'b0;
    wr(ADDR_R2_HYST, 8'h50);
    wr(ADDR_PWM2_FLOOR, DUTY_OFF);
    rd(ADDR_R2_HYST, 8'h50);
    expect_out(24'h400080, 6'h00);
    check(24'(spin), 24'h000005);
    @(posedge mclk);
    auto_mode <= 1'b1;
    wr(ADDR_PWM2_FLOOR, 8'h60);
    rd(ADDR_PWM2_FLOOR, DUTY_OFF);
    expect_out(24'h000000, 6'h00);
    $display("done: register access");
  endtask
  task automatic t_start();
    temps(8'h5B, 8'h19, 8'h19);
    expect_out(24'h500000, 6'b001000);
    temps(8'h5C, 8'h19, 8'h19);
    expect_out(24'h600000, 6'b001000);
    temps(8'h59, 8'h19, 8'h19);
    expect_out(24'h400000, 6'b001000);
    temps(8'h57, 8'h19, 8'h19);
    tick(4);
    expect_out(24'h400000, 6'b001000);
    temps(8'h56, 8'h19, 8'h19);
    expect_out(24'h000000, 6'h00);
    $display("done: start temperature");
  endtask
  task automatic t_crit();
    @(posedge mclk);
    alarm_as_output <= 1'b1;
    temps(8'h19, 8'h65, 8'h19);
    expect_out(24'hFFFFFF, 6'b010010);
    check(24'(alarm_pin), 24'h000000);
    temps(8'h19, 8'h60, 8'h19);
    tick(4);
    expect_out(24'hFFFFFF, 6'b010010);
    temps(8'h19, 8'h5F, 8'h19);
    expect_out(24'h005000, 6'b010000);
    check(24'(alarm_pin), 24'h000001);
    wr(ADDR_LOC_CRIT, CRIT_DISABLE_CODE);
    temps(8'h19, 8'h90, 8'h19);
    tick(4);
    expect_out(24'h00FF00, 6'b010000);
    temps(8'h19, 8'h19, 8'h65);
    expect_out(24'hFFFFFF, 6'b100100);
    temps(8'h19, 8'h19, 8'h19);
    expect_out(24'h000000, 6'h00);
    $display("done: critical limit");
  endtask
  initial
  begin
    tick(16);
    rst <= 1'b0;
    t_reset();
    t_regs();
    t_start();
    t_crit();
    end_of_test();
  end
endmodule
`default_nettype wire
